// file: shared/spi_front_regs.svh
// Timing counts, instruction codes and framing constants of the serial front end
`ifndef SPI_FRONT_REGS_SVH
`define SPI_FRONT_REGS_SVH

// ==========================================
// Instruction codes
`define OP_SET_WRITE_LATCH 8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_READ 8'h03
`define OP_ARRAY_WRITE 8'h02
`define OP_ID_PAGE_READ 8'h83
`define OP_ID_PAGE_WRITE 8'h82

// ==========================================
// Framing
`define ADDR_BYTES 3'h2
`define FIFO_DEPTH_DEFAULT 32
`define WRITE_CYCLE_US 4
`define CLK_MHZ 40

`endif

// file: shared/spi_front_pkg.sv
// Types shared by the serial front end modules
package spi_front_pkg;

    // ==========================================
    // Command classes
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_WRITE_TYPE = 3'b001,
        CMD_READ_TYPE = 3'b010,
        CMD_SET_LATCH = 3'b011,
        CMD_CLEAR_LATCH = 3'b100,
        CMD_INVALID = 3'b101
    } cmd_class_type;

    // ==========================================
    // Frame states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA_IN = 3'b011,
        ST_DATA_OUT = 3'b100,
        ST_WAIT_DESELECT = 3'b101
    } frame_state_type;

    // ==========================================
    // Write data word handed to the array side
    typedef struct packed {
        logic [7:0] opcode;
        logic [15:0] addr;
        logic [7:0] data;
    } write_word_type;

    // ==========================================
    // Synchronised and edge-detected pins
    typedef struct packed {
        logic clk_rise;
        logic clk_fall;
        logic clk_level;
        logic sel_fall;
        logic sel_rise;
        logic sel_n_level;
        logic pause_n_level;
        logic din_level;
    } pin_events_type;

endpackage : spi_front_pkg

// file: core/pin_sampler.sv
// Two-stage synchronisers and edge detection for the serial pins
`timescale 1ns/10ps
`default_nettype none

module pin_sampler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Raw pins
    input wire logic sclk_pin,
    input wire logic sel_n_pin,
    input wire logic pause_n_pin,
    input wire logic din_pin,
    // Events
    output var spi_front_pkg::pin_events_type events
);

    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] sync;
        logic [3:0] prev;
    } sampler_state_type;

    sampler_state_type state_reg;
    sampler_state_type state_next;

    always_comb begin
        state_next = state_reg;
        state_next.meta = {sclk_pin, sel_n_pin, pause_n_pin, din_pin};
        state_next.sync = state_reg.meta;
        state_next.prev = state_reg.sync;
    end

    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    // ==========================================
    // Edge decode reads only second and third stages
    always_comb begin
        events.clk_level = state_reg.sync[3];
        events.clk_rise = state_reg.sync[3] & ~state_reg.prev[3];
        events.clk_fall = ~state_reg.sync[3] & state_reg.prev[3];
        events.sel_n_level = state_reg.sync[2];
        events.sel_fall = ~state_reg.sync[2] & state_reg.prev[2];
        events.sel_rise = state_reg.sync[2] & ~state_reg.prev[2];
        events.pause_n_level = state_reg.sync[1];
        events.din_level = state_reg.sync[0];
        // Chain keeps sampling in reset, so a select held low is no edge
        // Limitation: reset must last three clocks to fill the chain
        if (!rst_n) begin
            events.clk_rise = 1'b0;
            events.clk_fall = 1'b0;
            events.sel_fall = 1'b0;
            events.sel_rise = 1'b0;
        end
    end

endmodule : pin_sampler

`default_nettype wire

// file: core/word_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } fifo_state_type;

    fifo_state_type state_reg;
    fifo_state_type state_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] fill;
    logic push;
    logic pop;

    always_comb begin
        fill = state_reg.wr_ptr - state_reg.rd_ptr;
        in_ready = (fill != (AW+1)'(DEPTH));
        out_valid = (fill != '0);
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        state_next = state_reg;
        if (push) begin
            state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
        end
        if (!rst_n) begin
            state_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        state_reg <= state_next;
        if (push) begin
            mem[state_reg.wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Output comes straight from the storage array
    assign out_data = mem[state_reg.rd_ptr[AW-1:0]];

endmodule : word_fifo

`default_nettype wire

// file: core/spi_front_end.sv
// Serial bus front end: framing, pause, standby and write acceptance
`timescale 1ns/10ps
`default_nettype none
`include "spi_front_regs.svh"

module spi_front_end #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT,
    parameter int WRITE_CYCLE_CYCLES = `WRITE_CYCLE_US * `CLK_MHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic sclk_pin,
    input wire logic sel_n_pin,
    input wire logic pause_n_pin,
    input wire logic din_pin,
    output logic dout,
    output logic dout_oe_n,
    // Read data source
    input wire logic [7:0] rd_byte,
    output logic rd_byte_req,
    // Accepted write words
    output logic wr_valid,
    input wire logic wr_ready,
    output var spi_front_pkg::write_word_type wr_word,
    // Status
    output logic write_enable_latch,
    output logic write_busy,
    output logic standby
);

    localparam int CNT_W = $clog2(WRITE_CYCLE_CYCLES + 1);

    spi_front_pkg::pin_events_type ev;

    typedef struct packed {
        spi_front_pkg::frame_state_type fstate;
        spi_front_pkg::cmd_class_type cls;
        logic armed;
        logic paused;
        logic [2:0] bit_cnt;
        logic [1:0] addr_cnt;
        logic [7:0] shift_in;
        logic [7:0] opcode;
        logic [15:0] addr;
        logic [7:0] shift_out;
        logic out_en;
        logic dout;
        logic data_seen;
        logic latch;
        logic [CNT_W-1:0] wcycle;
        logic req;
    } front_state_type;

    front_state_type state_reg;
    front_state_type state_next;

    logic fifo_in_valid;
    logic fifo_in_ready;
    spi_front_pkg::write_word_type fifo_in_word;

    pin_sampler u_sampler (
        .clk(clk),
        .rst_n(rst_n),
        .sclk_pin(sclk_pin),
        .sel_n_pin(sel_n_pin),
        .pause_n_pin(pause_n_pin),
        .din_pin(din_pin),
        .events(ev)
    );

    word_fifo #(
        .WIDTH($bits(spi_front_pkg::write_word_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_word),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_word)
    );

    // ==========================================
    // Opcode classification
    function automatic spi_front_pkg::cmd_class_type classify(input logic [7:0] op);
        if (op == `OP_ARRAY_WRITE || op == `OP_STATUS_WRITE || op == `OP_ID_PAGE_WRITE) begin
            return spi_front_pkg::CMD_WRITE_TYPE;
        end else if (op == `OP_ARRAY_READ || op == `OP_STATUS_READ
                     || op == `OP_ID_PAGE_READ) begin
            return spi_front_pkg::CMD_READ_TYPE;
        end else if (op == `OP_SET_WRITE_LATCH) begin
            return spi_front_pkg::CMD_SET_LATCH;
        end else if (op == `OP_CLEAR_WRITE_LATCH) begin
            return spi_front_pkg::CMD_CLEAR_LATCH;
        end
        return spi_front_pkg::CMD_INVALID;
    endfunction : classify

    // Status commands carry no address bytes
    function automatic logic has_addr(input logic [7:0] op);
        return (op != `OP_STATUS_READ) && (op != `OP_STATUS_WRITE);
    endfunction : has_addr

    // ==========================================
    // Frame logic
    logic sclk_live;
    logic [7:0] byte_now;

    always_comb begin
        state_next = state_reg;
        state_next.req = 1'b0;
        fifo_in_valid = 1'b0;
        fifo_in_word = '{opcode: state_reg.opcode, addr: state_reg.addr,
                         data: state_reg.shift_in};
        byte_now = {state_reg.shift_in[6:0], ev.din_level};
        sclk_live = !state_reg.paused && state_reg.armed && !ev.sel_n_level;

        // Write cycle countdown; latch cleared once it ends
        if (state_reg.wcycle != '0) begin
            state_next.wcycle = state_reg.wcycle - 1'b1;
            if (state_reg.wcycle == CNT_W'(1)) begin
                state_next.latch = 1'b0;
            end
        end

        // Pause entry only with clock low; exit with clock low or on either select edge
        if (!ev.sel_n_level && !ev.clk_level) begin
            state_next.paused = !ev.pause_n_level;
        end

        if (ev.sel_fall) begin
            state_next.armed = 1'b1;
            state_next.paused = 1'b0;
            state_next.fstate = spi_front_pkg::ST_OPCODE;
            state_next.bit_cnt = 3'h0;
            state_next.addr_cnt = 2'h0;
            state_next.data_seen = 1'b0;
            state_next.cls = spi_front_pkg::CMD_NONE;
        end else if (ev.sel_rise) begin
            // Write launches only at a byte boundary after data, and never while paused
            if (state_reg.armed && !state_reg.paused
                && state_reg.fstate == spi_front_pkg::ST_DATA_IN
                && state_reg.bit_cnt == 3'h0 && state_reg.data_seen) begin
                state_next.wcycle = CNT_W'(WRITE_CYCLE_CYCLES);
            end
            // Mid-byte rise or pause drops the command
            state_next.fstate = spi_front_pkg::ST_IDLE;
            state_next.paused = 1'b0;
            state_next.out_en = 1'b0;
        end else if (sclk_live && ev.clk_rise) begin
            state_next.shift_in = byte_now;
            state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
            case (state_reg.fstate)
                spi_front_pkg::ST_OPCODE: begin
                    if (state_reg.bit_cnt == 3'h7) begin
                        state_next.opcode = byte_now;
                        state_next.cls = classify(byte_now);
                        state_next.addr = '0;
                        case (classify(byte_now))
                            spi_front_pkg::CMD_SET_LATCH: begin
                                state_next.latch = state_reg.wcycle == '0;
                                state_next.fstate = spi_front_pkg::ST_WAIT_DESELECT;
                            end
                            spi_front_pkg::CMD_CLEAR_LATCH: begin
                                state_next.latch = 1'b0;
                                state_next.fstate = spi_front_pkg::ST_WAIT_DESELECT;
                            end
                            spi_front_pkg::CMD_WRITE_TYPE: begin
                                // busy or unlatched writes are dropped
                                if (!state_reg.latch || state_reg.wcycle != '0) begin
                                    state_next.fstate = spi_front_pkg::ST_WAIT_DESELECT;
                                end else if (has_addr(byte_now)) begin
                                    state_next.fstate = spi_front_pkg::ST_ADDR;
                                end else begin
                                    state_next.fstate = spi_front_pkg::ST_DATA_IN;
                                end
                            end
                            spi_front_pkg::CMD_READ_TYPE: begin
                                if (has_addr(byte_now)) begin
                                    state_next.fstate = spi_front_pkg::ST_ADDR;
                                end else begin
                                    state_next.fstate = spi_front_pkg::ST_DATA_OUT;
                                    state_next.req = 1'b1;
                                end
                            end
                            default: begin
                                state_next.fstate = spi_front_pkg::ST_WAIT_DESELECT;
                            end
                        endcase
                    end
                end
                spi_front_pkg::ST_ADDR: begin
                    if (state_reg.bit_cnt == 3'h7) begin
                        state_next.addr = {state_reg.addr[7:0], byte_now};
                        state_next.addr_cnt = state_reg.addr_cnt + 2'h1;
                        if ({1'b0, state_reg.addr_cnt} == `ADDR_BYTES - 3'h1) begin
                            if (state_reg.cls == spi_front_pkg::CMD_READ_TYPE) begin
                                state_next.fstate = spi_front_pkg::ST_DATA_OUT;
                                state_next.req = 1'b1;
                            end else begin
                                state_next.fstate = spi_front_pkg::ST_DATA_IN;
                            end
                        end
                    end
                end
                spi_front_pkg::ST_DATA_IN: begin
                    if (state_reg.bit_cnt == 3'h7) begin
                        // Full buffer ends the frame: this byte and later ones are lost
                        if (fifo_in_ready) begin
                            fifo_in_valid = 1'b1;
                            fifo_in_word.data = byte_now;
                            state_next.data_seen = 1'b1;
                            state_next.addr = state_reg.addr + 16'h0001;
                        end else begin
                            state_next.fstate = spi_front_pkg::ST_WAIT_DESELECT;
                        end
                    end
                end
                spi_front_pkg::ST_DATA_OUT: begin
                    if (state_reg.bit_cnt == 3'h7) begin
                        state_next.req = 1'b1;
                    end
                end
                default: begin
                    state_next.bit_cnt = state_reg.bit_cnt;
                end
            endcase
        end else if (sclk_live && ev.clk_fall
                     && state_reg.fstate == spi_front_pkg::ST_DATA_OUT) begin
            // First fall after decode loads a fresh byte
            if (state_reg.bit_cnt == 3'h0) begin
                state_next.dout = rd_byte[7];
                state_next.shift_out = {rd_byte[6:0], 1'b0};
            end else begin
                state_next.dout = state_reg.shift_out[7];
                state_next.shift_out = {state_reg.shift_out[6:0], 1'b0};
            end
            state_next.out_en = 1'b1;
        end

        // Pause only masks the enable below, so driving resumes with the held bit
        if (ev.sel_n_level) begin
            state_next.out_en = 1'b0;
        end

        if (!rst_n) begin
            state_next = '0;
            state_next.fstate = spi_front_pkg::ST_IDLE;
            state_next.cls = spi_front_pkg::CMD_NONE;
        end
    end

    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    // ==========================================
    // Outputs
    assign dout = state_reg.dout;
    assign dout_oe_n = !(state_reg.out_en && !state_reg.paused
                         && !ev.sel_n_level);
    assign rd_byte_req = state_reg.req;
    assign write_enable_latch = state_reg.latch;
    assign write_busy = state_reg.wcycle != '0;
    assign standby = ev.sel_n_level && state_reg.wcycle == '0;

endmodule : spi_front_end

`default_nettype wire

// file: test/spi_master_model.sv
// Bus master model that drives the serial pins of the front end
`timescale 1ns/10ps
`default_nettype none

module spi_master_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic sclk_pin,
    output logic sel_n_pin,
    output logic pause_n_pin,
    output logic din_pin,
    input wire logic dout,
    input wire logic dout_oe_n
);
    logic cpol = 1'b0;

    // ==========================================
    // Select starts low, as if held down at power-up
    initial begin
        sclk_pin = 1'b0;
        sel_n_pin = 1'b0;
        pause_n_pin = 1'b1;
        din_pin = 1'b0;
    end

    // ==========================================
    // Pins move by non-blocking assignment on the clock edge; the sampler resyncs them
    task automatic idle(input logic pol);
        cpol = pol;
        @(posedge clk);
        sclk_pin <= pol;
        repeat (4) @(posedge clk);
    endtask : idle

    // Data line toggles on every select change so a stale value never looks valid
    task automatic select(input logic on);
        @(posedge clk);
        sclk_pin <= cpol;
        repeat (4) @(posedge clk);
        sel_n_pin <= !on;
        din_pin <= !din_pin;
        repeat (4) @(posedge clk);
    endtask : select

    // A released output reads as its inverse, so a missing drive corrupts the byte
    task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            sclk_pin <= 1'b0;
            din_pin <= tx[i];
            repeat (4) @(posedge clk);
            sclk_pin <= 1'b1;
            rx = {rx[6:0], dout_oe_n ? !dout : dout};
            repeat (3) @(posedge clk);
        end
    endtask : shift

    // Clock and data wiggle while paused; the device must ignore them
    task automatic pause(input logic on);
        @(posedge clk);
        sclk_pin <= 1'b0;
        repeat (4) @(posedge clk);
        pause_n_pin <= !on;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 2 && on; i++) begin
            sclk_pin <= 1'b1;
            din_pin <= !din_pin;
            repeat (4) @(posedge clk);
            sclk_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : pause
endmodule : spi_master_model

`default_nettype wire

// file: test/spi_front_end_asserts.sv
// Concurrent checks on the ports of the serial front end
`timescale 1ns/10ps
`default_nettype none

module spi_front_end_asserts #(
    parameter int WRITE_CYCLE_CYCLES = 160
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic sclk_pin,
    input wire logic sel_n_pin,
    input wire logic pause_n_pin,
    input wire logic dout_oe_n,
    // Write side and status
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire spi_front_pkg::write_word_type wr_word,
    input wire logic write_enable_latch,
    input wire logic write_busy,
    input wire logic standby
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================
    // Busy length; saturates so a stuck busy cannot wrap into a pass
    logic [15:0] busy_cnt_reg;
    always_ff @(posedge clk) begin
        if (!rst_n || !write_busy) begin
            busy_cnt_reg <= 16'h0000;
        end else if (busy_cnt_reg != 16'hffff) begin
            busy_cnt_reg <= busy_cnt_reg + 16'h0001;
        end
    end

    // ==========================================
    // Assertions
    a_reset_quiet: assert property ($rose(rst_n) |-> dout_oe_n && !write_enable_latch
        && !write_busy && !wr_valid) else $error("outputs active after reset");
    a_oe_desel: assert property (sel_n_pin [*4] |-> dout_oe_n)
        else $error("output driven while deselected");
    a_oe_pause: assert property ((!pause_n_pin && !sclk_pin && !sel_n_pin) [*6] |-> dout_oe_n)
        else $error("output driven while paused");
    a_standby_idle: assert property ((sel_n_pin && !write_busy) [*6] |-> standby)
        else $error("no standby when idle");
    a_busy_standby: assert property (write_busy |-> !standby)
        else $error("standby during write cycle");
    a_busy_len: assert property ($fell(write_busy) |-> busy_cnt_reg >= WRITE_CYCLE_CYCLES
        && busy_cnt_reg <= WRITE_CYCLE_CYCLES + 1) else $error("write cycle length wrong");
    a_latch_clear: assert property ($fell(write_busy) |-> ##[0:1] !write_enable_latch)
        else $error("latch kept after write cycle");
    a_busy_desel: assert property ($rose(write_busy) |-> sel_n_pin)
        else $error("write cycle started while selected");
    a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
        else $error("write word dropped or changed while stalled");

    cover property ($rose(write_busy));
    cover property (wr_valid && !wr_ready);
    cover property (!pause_n_pin && !sel_n_pin && dout_oe_n);
endmodule : spi_front_end_asserts

bind spi_front_end spi_front_end_asserts #(
    .WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)
) chk_u (
    .clk(clk),
    .rst_n(rst_n),
    .sclk_pin(sclk_pin),
    .sel_n_pin(sel_n_pin),
    .pause_n_pin(pause_n_pin),
    .dout_oe_n(dout_oe_n),
    .wr_valid(wr_valid),
    .wr_ready(wr_ready),
    .wr_word(wr_word),
    .write_enable_latch(write_enable_latch),
    .write_busy(write_busy),
    .standby(standby)
);

`default_nettype wire

// file: test/spi_front_end_tb.sv
// Self-checking bench for the serial front end
`timescale 1ns/10ps
`default_nettype none
`include "spi_front_regs.svh"

module spi_front_end_tb;
    localparam int WCYC = 20;
    typedef struct {logic [7:0] op; int nbytes; int xbits; logic busy; logic latch;} row_type;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk_pin, sel_n_pin, pause_n_pin, din_pin, dout, dout_oe_n;
    logic rd_byte_req, wr_valid, write_enable_latch, write_busy, standby;
    logic wr_ready = 1'b1;
    logic [7:0] rd_byte = 8'h11;
    logic [7:0] rx, rx2, exp;
    logic busy_seen = 1'b0;
    spi_front_pkg::write_word_type wr_word;
    int fail_count = 0;
    int num_checks = 0;
    int n;
    // Filler bytes are 06 so a decoder that wakes up mid-frame would set the latch
    row_type rows [12] = '{
        '{`OP_SET_WRITE_LATCH, 0, 0, 1'b0, 1'b1}, '{`OP_CLEAR_WRITE_LATCH, 0, 0, 1'b0, 1'b0},
        '{`OP_ARRAY_WRITE, 3, 0, 1'b0, 1'b0}, '{`OP_SET_WRITE_LATCH, 0, 0, 1'b0, 1'b1},
        '{`OP_ARRAY_WRITE, 2, 0, 1'b0, 1'b1}, '{`OP_ARRAY_WRITE, 3, 3, 1'b0, 1'b1},
        '{`OP_ARRAY_WRITE, 3, 0, 1'b1, 1'b0}, '{8'hff, 1, 0, 1'b0, 1'b0},
        '{`OP_SET_WRITE_LATCH, 0, 0, 1'b0, 1'b1}, '{`OP_STATUS_WRITE, 1, 0, 1'b1, 1'b0},
        '{`OP_SET_WRITE_LATCH, 0, 0, 1'b0, 1'b1}, '{`OP_ID_PAGE_WRITE, 3, 0, 1'b1, 1'b0}};

    always #12.5 clk = !clk;

    always @(posedge clk) begin
        if (rd_byte_req === 1'b1) begin
            rd_byte <= rd_byte + 8'h11;
        end
        if (write_busy === 1'b1) begin
            busy_seen <= 1'b1;
        end
    end

    spi_master_model m (.clk(clk), .sclk_pin(sclk_pin), .sel_n_pin(sel_n_pin),
        .pause_n_pin(pause_n_pin), .din_pin(din_pin), .dout(dout), .dout_oe_n(dout_oe_n));

    spi_front_end #(.FIFO_DEPTH(32), .WRITE_CYCLE_CYCLES(WCYC)) dut_u (.clk(clk),
        .rst_n(rst_n), .sclk_pin(sclk_pin), .sel_n_pin(sel_n_pin), .pause_n_pin(pause_n_pin),
        .din_pin(din_pin), .dout(dout), .dout_oe_n(dout_oe_n), .rd_byte(rd_byte),
        .rd_byte_req(rd_byte_req), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
        .write_enable_latch(write_enable_latch), .write_busy(write_busy), .standby(standby));

    // ==========================================
    // Shared tasks
    task automatic check_vec(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, want);
        end
    endtask : check_vec

    task automatic frame(input logic [7:0] op, input int nbytes, input int xbits);
        m.select(1'b1);
        m.shift(8, op, rx);
        for (int i = 0; i < nbytes; i++) begin
            m.shift(8, `OP_SET_WRITE_LATCH, rx);
        end
        if (xbits > 0) begin
            m.shift(xbits, 8'h05, rx);
        end
        m.select(1'b0);
    endtask : frame

    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check_vec({dout_oe_n, write_enable_latch, write_busy, wr_valid}, 4'h8);
        m.shift(8, `OP_SET_WRITE_LATCH, rx);
        m.select(1'b0);
        check_vec(write_enable_latch, 1'b0);
        for (int i = 0; i < 12; i++) begin
            m.idle(i[0]);
            busy_seen <= 1'b0;
            frame(rows[i].op, rows[i].nbytes, rows[i].xbits);
            repeat (WCYC + 20) @(posedge clk);
            check_vec(busy_seen, rows[i].busy);
            check_vec(write_enable_latch, rows[i].latch);
        end
        check_vec(standby, 1'b1);
        m.idle(1'b0);
        exp = rd_byte + 8'h11;
        m.select(1'b1);
        m.shift(8, `OP_ARRAY_READ, rx);
        m.shift(8, 8'h00, rx);
        m.shift(8, 8'h10, rx);
        m.shift(4, 8'h00, rx);
        m.pause(1'b1);
        check_vec(dout_oe_n, 1'b1);
        m.pause(1'b0);
        m.shift(4, 8'h00, rx2);
        check_vec({rx[3:0], rx2[3:0]}, exp);
        m.shift(8, 8'h00, rx);
        check_vec(rx, exp + 8'h11);
        check_vec(dout_oe_n, 1'b0);
        m.select(1'b0);
        check_vec(dout_oe_n, 1'b1);
        m.select(1'b1);
        m.shift(4, 8'h00, rx);
        m.pause(1'b1);
        m.select(1'b0);
        m.pause(1'b0);
        m.select(1'b1);
        m.shift(4, 8'h06, rx);
        m.select(1'b0);
        check_vec(write_enable_latch, 1'b0);
        frame(`OP_SET_WRITE_LATCH, 0, 0);
        wr_ready <= 1'b0;
        frame(`OP_ARRAY_WRITE, 36, 0);
        check_vec(wr_word, {`OP_ARRAY_WRITE, 16'h0606, 8'h06});
        wr_ready <= 1'b1;
        n = 0;
        repeat (100) begin
            @(posedge clk);
            if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
                n++;
            end
        end
        check_vec(n, 32);
        check_vec(write_enable_latch, 1'b1);
        // Mid-run reset stands in for a second power-up
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check_vec({dout_oe_n, write_enable_latch, write_busy, wr_valid}, 4'h8);
        repeat (WCYC + 20) @(posedge clk);
        finish_test();
    end
endmodule : spi_front_end_tb

`default_nettype wire
